// *** design/pfs_status_bank.sv ***
// latched fault and warning status bytes for a two-channel power module
// assumes event inputs are one-cycle pulses on clk, the link request
// port is logic on link_clk, and temp_sense_input comes from a pin
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] input byte bit 7 latches overvoltage fault
// [R2] unsupported status bits always read zero
// [R3] input byte bit 4 latches undervoltage fault
// [R4] input bit 3 latches unit off, low input
// [R5] input bits 2,1 latch overcurrent fault, warning
// [R6] input bit 0 latches overpower warning
// [R7] writing one clears supported bit, zero keeps
// [R8] input byte shared by both channels, page ignored
// [R9] temperature byte paged: 00h a, 01h b
// [R10] page ffh reads return channel a
// [R11] temperature bit 7 latches overtemperature fault
// [R12] temperature bit 6 latches overtemperature warning
// [R13] temperature bits 3..0 always read zero
// [R14] comm/logic/memory byte shared, page ignored
// [R15] comm bit 7 latches bad command code
// [R16] comm bit 6 latches bad payload data
// [R17] comm bit 5 latches packet check failure
// [R18] comm bit 3 memory error; 4,2 read zero
// [R19] comm bit 1 latches other comm fault
// [R20] vendor byte paged per channel like temperature
// [R21] vendor byte field layout, vid reset page 0
// [R22] share fault after seven consecutive imbalance detections
// [R23] phase count above max warns and clamps
// [R24] temp sense level caught before soft-start
// [R25] flags stay set until cleared or reset
module pfs_status_bank (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic txn_valid,
    input wire pfs_pkg::pfs_txn_t txn,
    output logic txn_busy,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    input wire pfs_pkg::pfs_input_evt_t input_evt,
    input wire pfs_pkg::pfs_chan_evt_t [1:0] chan_evt,
    input wire pfs_pkg::pfs_comm_evt_t comm_evt,
    input wire logic detect_cycle,
    input wire logic [3:0] phase_imbalance_warn,
    input wire logic [1:0] temp_sense_input,
    input wire logic [1:0] soft_start_begin,
    input wire logic [1:0] phase_count_load,
    input wire logic [1:0][2:0] phase_count_select,
    output logic [1:0][2:0] operating_phase_count
);
    import pfs_pkg::*;

    // ----
    // link side: take a request, hold it, signal the core by toggle
    // ----
    pfs_txn_t link_txn_reg;
    logic req_tgl_reg;
    logic busy_reg;
    logic [1:0] ack_sync_reg;
    logic ack_seen_reg;
    logic rsp_valid_reg;
    logic [7:0] rsp_data_reg;
    logic link_take;
    logic link_done;

    // core side crossing state
    logic [1:0] req_sync_reg;
    logic req_seen_reg;
    logic ack_tgl_reg;
    logic [7:0] rsp_hold_reg;

    assign link_take = txn_valid & ~busy_reg;
    assign link_done = ack_sync_reg[1] ^ ack_seen_reg;

    // the request word stays frozen while busy, so the core may read it
    // as a bus once the toggle has crossed
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_txn_reg <= '0;
            req_tgl_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            if (link_take) begin
                link_txn_reg <= txn;
                req_tgl_reg <= ~req_tgl_reg;
            end
            busy_reg <= link_take | (busy_reg & ~link_done);
        end
    end

    // answer comes back by toggle; the hold byte is stable by then
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_sync_reg <= 2'h0;
            ack_seen_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= STATUS_RESET;
        end else begin
            ack_sync_reg <= {ack_sync_reg[0], ack_tgl_reg};
            ack_seen_reg <= ack_sync_reg[1];
            rsp_valid_reg <= link_done;
            if (link_done) begin
                rsp_data_reg <= rsp_hold_reg;
            end
        end
    end

    assign txn_busy = busy_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;

    // ----
    // core side: receive request toggle, decode
    // ----
    logic core_go;
    logic go_wr;
    logic go_rd;
    logic hit_input;
    logic hit_temp;
    logic hit_cml;
    logic hit_vendor;
    logic hit_paged;
    logic page_is_a;
    logic page_is_b;
    logic page_is_all;
    logic page_ok;
    logic cmd_unknown;
    logic page_bad;
    logic read_b;
    logic [1:0] wr_chan;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_sync_reg <= 2'h0;
            req_seen_reg <= 1'b0;
        end else begin
            req_sync_reg <= {req_sync_reg[0], req_tgl_reg};
            req_seen_reg <= req_sync_reg[1];
        end
    end

    assign core_go = req_sync_reg[1] ^ req_seen_reg;
    assign go_wr = core_go & link_txn_reg.write;
    assign go_rd = core_go & ~link_txn_reg.write;

    // command decode; anything else is not served by this bank
    assign hit_input = link_txn_reg.cmd == CMD_INPUT_STATUS;
    assign hit_temp = link_txn_reg.cmd == CMD_TEMP_STATUS;
    assign hit_cml = link_txn_reg.cmd == CMD_CML_STATUS;
    assign hit_vendor = link_txn_reg.cmd == CMD_VENDOR_STATUS;
    assign hit_paged = hit_temp | hit_vendor;
    assign cmd_unknown = ~(hit_input | hit_cml | hit_paged);

    // page decode; shared bytes never look at it
    assign page_is_a = link_txn_reg.page == PAGE_CHAN_A;
    assign page_is_b = link_txn_reg.page == PAGE_CHAN_B;
    assign page_is_all = link_txn_reg.page == PAGE_ALL;
    assign page_ok = page_is_a | page_is_b | page_is_all;
    assign page_bad = hit_paged & ~page_ok;
    assign read_b = page_is_b; // R9 R10
    // a write at page ffh clears both channels
    assign wr_chan = {page_is_b | page_is_all, page_is_a | page_is_all};

    // ----
    // temp sense pin synchroniser
    // ----
    logic [1:0] tsense_meta_reg;
    logic [1:0] tsense_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tsense_meta_reg <= 2'h0;
            tsense_reg <= 2'h0;
        end else begin
            tsense_meta_reg <= temp_sense_input;
            tsense_reg <= tsense_meta_reg;
        end
    end

    // ----
    // phase share watch: consecutive imbalance detections per phase
    // ----
    logic [NUM_PHASE-1:0] phase_hit;
    logic [1:0] share_fault_set;

    genvar p;
    generate
        for (p = 0; p < NUM_PHASE; p++) begin : g_phase
            logic [2:0] run_reg;
            logic [2:0] run_next;
            // saturate so a long imbalance does not wrap and re-arm
            assign run_next = !phase_imbalance_warn[p] ? 3'h0 :
                (run_reg == PHASE_FLT_CYCLES) ? run_reg :
                run_reg + 3'h1;
            assign phase_hit[p] = detect_cycle & phase_imbalance_warn[p] &
                (run_reg == PHASE_FLT_CYCLES - 3'h1); // R22
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    run_reg <= 3'h0;
                end else if (detect_cycle) begin
                    run_reg <= run_next;
                end
            end
        end
    endgenerate

    assign share_fault_set[0] = |(phase_hit & ~PHASE_ON_CHAN_B); // R22
    assign share_fault_set[1] = |(phase_hit & PHASE_ON_CHAN_B);

    // ----
    // shared bytes: input supply and comm/logic/memory
    // ----
    logic [7:0] input_reg;
    logic [7:0] input_next;
    logic [7:0] input_set;
    logic [7:0] input_clr;
    logic [7:0] cml_reg;
    logic [7:0] cml_next;
    logic [7:0] cml_set;
    logic [7:0] cml_clr;

    // event bits into their byte positions
    always_comb begin
        input_set = 8'h00;
        input_set[IN_OV_FAULT] = input_evt.input_overvoltage_fault; // R1
        input_set[IN_UV_FAULT] = input_evt.input_undervoltage_fault; // R3
        input_set[IN_UNIT_OFF] = input_evt.unit_off_insufficient_input; // R4
        input_set[IN_OC_FAULT] = input_evt.input_overcurrent_fault; // R5
        input_set[IN_OC_WARN] = input_evt.input_overcurrent_warning; // R5
        input_set[IN_OP_WARN] = input_evt.input_overpower_warning; // R6
        cml_set = 8'h00;
        // an unknown command code is caught on reads as well as writes
        cml_set[CML_BAD_CMD] = go_rd & cmd_unknown |
            go_wr & cmd_unknown; // R15
        cml_set[CML_BAD_PAYLOAD] = comm_evt.bad_payload_flag |
            core_go & page_bad; // R16
        cml_set[CML_PACKET_CHECK_FAILURE] = comm_evt.packet_check_failure; // R17
        cml_set[CML_MEM_ERR] = comm_evt.memory_error; // R18
        cml_set[OTHER_LOGIC_FAULT_COMM] = comm_evt.other_comm_fault; // R19
    end

    // clears ignore the page for shared bytes
    assign input_clr = (go_wr & hit_input) ? link_txn_reg.wdata : 8'h00; // R8
    assign cml_clr = (go_wr & hit_cml) ? link_txn_reg.wdata : 8'h00; // R14
    // set beats clear in the same cycle so no event is lost
    assign input_next = ((input_reg & ~input_clr) | input_set) &
        INPUT_MASK; // R2 R7 R25
    assign cml_next = ((cml_reg & ~cml_clr) | cml_set) & CML_MASK; // R18 R7

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            input_reg <= STATUS_RESET;
            cml_reg <= STATUS_RESET;
        end else begin
            input_reg <= input_next;
            cml_reg <= cml_next;
        end
    end

    // ----
    // paged bytes: temperature and vendor status, phase limiting
    // ----
    logic [1:0][7:0] temp_reg;
    logic [1:0][7:0] vendor_reg;
    logic [1:0][2:0] phase_cnt_reg;

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            logic [7:0] temp_set;
            logic [7:0] temp_clr;
            logic [7:0] temp_next;
            logic [7:0] vnd_set;
            logic [7:0] vnd_clr;
            logic [7:0] vnd_next;
            logic over_max;
            logic [2:0] phase_next;
            logic clr_here;

            assign clr_here = go_wr & wr_chan[c];
            assign over_max = phase_count_select[c] > PHASE_MAX[c];
            assign phase_next = over_max ? PHASE_MAX[c] :
                phase_count_select[c]; // R23

            always_comb begin
                temp_set = 8'h00;
                temp_set[TMP_OT_FAULT] =
                    chan_evt[c].overtemperature_fault; // R11
                temp_set[TMP_OT_WARN] =
                    chan_evt[c].overtemperature_warning; // R12
                vnd_set = 8'h00;
                vnd_set[VND_POWER_STAGE] =
                    chan_evt[c].power_stage_fault; // R21
                vnd_set[VND_SENSE_OPEN] = chan_evt[c].sense_pin_open_flag;
                vnd_set[VND_PHASE_LIMIT] =
                    phase_count_load[c] & over_max; // R23
                // level at or above threshold when soft-start begins
                vnd_set[VND_TSENSE_LOW] =
                    soft_start_begin[c] & tsense_reg[c]; // R24
                vnd_set[VND_VID_RESET] = chan_evt[c].voltage_id_reset_flag;
                vnd_set[VND_PHASE_SHARE] = share_fault_set[c]; // R22
            end

            assign temp_clr = (clr_here & hit_temp) ?
                link_txn_reg.wdata : 8'h00; // R9
            assign vnd_clr = (clr_here & hit_vendor) ?
                link_txn_reg.wdata : 8'h00; // R20
            // masks keep unsupported, reserved and page-1 vid bits at zero
            assign temp_next = ((temp_reg[c] & ~temp_clr) | temp_set) &
                TEMP_MASK; // R2 R13 R7 R25
            assign vnd_next = ((vendor_reg[c] & ~vnd_clr) | vnd_set) &
                VENDOR_MASK[c]; // R21 R7 R25

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    temp_reg[c] <= STATUS_RESET;
                    vendor_reg[c] <= STATUS_RESET;
                end else begin
                    temp_reg[c] <= temp_next;
                    vendor_reg[c] <= vnd_next;
                end
            end

            // operating count follows each load, clamped to the hardware
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    phase_cnt_reg[c] <= PHASE_COUNT_RESET;
                end else if (phase_count_load[c]) begin
                    phase_cnt_reg[c] <= phase_next; // R23
                end
            end
        end
    endgenerate

    assign operating_phase_count = phase_cnt_reg;

    // ----
    // read selection and answer back to the link
    // ----
    logic [7:0] rd_temp;
    logic [7:0] rd_vendor;
    logic [7:0] rd_paged;
    logic [7:0] rd_byte;

    // page ffh and 00h both pick channel a
    assign rd_temp = read_b ? temp_reg[1] : temp_reg[0]; // R9 R10
    assign rd_vendor = read_b ? vendor_reg[1] : vendor_reg[0]; // R20 R10
    assign rd_paged = !page_ok ? 8'h00 : hit_temp ? rd_temp : rd_vendor;
    // writes answer zero; an unknown code reads zero
    assign rd_byte = link_txn_reg.write ? 8'h00 :
        hit_input ? input_reg : // R8
        hit_cml ? cml_reg : // R14
        hit_paged ? rd_paged : 8'h00;

    // the byte is captured before this cycle's clear or set lands, so a
    // read shows the state the host asked about
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_hold_reg <= STATUS_RESET;
            ack_tgl_reg <= 1'b0;
        end else if (core_go) begin
            rsp_hold_reg <= rd_byte;
            ack_tgl_reg <= ~ack_tgl_reg;
        end
    end

endmodule

`default_nettype wire

// *** design/pfs_pkg.sv ***
// constants, field positions and carrier types for the fault status bank
// assumes the fault detectors and the link-side transaction engine sit
// outside and hand over single-cycle event pulses and whole byte requests
package pfs_pkg;

    // ----
    // geometry
    // ----
    localparam int NUM_CHAN = 2;
    localparam int NUM_PHASE = 4;
    // phases 0..2 drive channel a, phase 3 drives channel b
    localparam logic [3:0] PHASE_ON_CHAN_B = 4'h8;
    localparam logic [1:0][2:0] PHASE_MAX = {3'h1, 3'h3};

    // ----
    // command codes and page values
    // ----
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
    localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
    localparam logic [7:0] CMD_CML_STATUS = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] PAGE_CHAN_A = 8'h00;
    localparam logic [7:0] PAGE_CHAN_B = 8'h01;
    localparam logic [7:0] PAGE_ALL = 8'hff;

    // ----
    // field positions
    // ----
    localparam int IN_OV_FAULT = 7;
    localparam int IN_UV_FAULT = 4;
    localparam int IN_UNIT_OFF = 3;
    localparam int IN_OC_FAULT = 2;
    localparam int IN_OC_WARN = 1;
    localparam int IN_OP_WARN = 0;
    localparam int TMP_OT_FAULT = 7;
    localparam int TMP_OT_WARN = 6;
    localparam int CML_BAD_CMD = 7;
    localparam int CML_BAD_PAYLOAD = 6;
    localparam int CML_PACKET_CHECK_FAILURE = 5;
    localparam int CML_MEM_ERR = 3;
    localparam int OTHER_LOGIC_FAULT_COMM = 1;
    localparam int VND_POWER_STAGE = 7;
    localparam int VND_SENSE_OPEN = 6;
    localparam int VND_PHASE_LIMIT = 5;
    localparam int VND_TSENSE_LOW = 4;
    localparam int VND_VID_RESET = 3;
    localparam int VND_PHASE_SHARE = 0;

    // ----
    // supported-bit masks and reset values
    // ----
    localparam logic [7:0] INPUT_MASK = 8'h9f;
    localparam logic [7:0] TEMP_MASK = 8'hc0;
    localparam logic [7:0] CML_MASK = 8'hea;
    localparam logic [1:0][7:0] VENDOR_MASK = {8'hf1, 8'hf9};
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] PHASE_COUNT_RESET = 3'h0;

    // ----
    // timing
    // ----
    // imbalance detections in a row before a share fault latches
    localparam logic [2:0] PHASE_FLT_CYCLES = 3'h7;

    // ----
    // carriers
    // ----
    typedef struct packed {
        logic write;
        logic [7:0] cmd;
        logic [7:0] page;
        logic [7:0] wdata;
    } pfs_txn_t;

    typedef struct packed {
        logic input_overvoltage_fault;
        logic input_undervoltage_fault;
        logic unit_off_insufficient_input;
        logic input_overcurrent_fault;
        logic input_overcurrent_warning;
        logic input_overpower_warning;
    } pfs_input_evt_t;

    typedef struct packed {
        logic overtemperature_fault;
        logic overtemperature_warning;
        logic power_stage_fault;
        logic sense_pin_open_flag;
        logic voltage_id_reset_flag;
    } pfs_chan_evt_t;

    typedef struct packed {
        logic bad_payload_flag;
        logic packet_check_failure;
        logic memory_error;
        logic other_comm_fault;
    } pfs_comm_evt_t;

endpackage

// *** verif/pfs_chk.sv ***
// assertions on the link handshake and phase count ports of the bank
// assumes it is bound onto pfs_status_bank by the bench top file
`timescale 1ns/10ps
`default_nettype none
module pfs_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic txn_valid,
    input wire pfs_pkg::pfs_txn_t txn,
    input wire logic txn_busy,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic [1:0] phase_count_load,
    input wire logic [1:0][2:0] phase_count_select,
    input wire logic [1:0][2:0] operating_phase_count
);
    import pfs_pkg::*;
    // ----
    // helper: kind of the request in flight
    // ----
    logic wr_reg;
    wire logic take;
    assign take = txn_valid && !txn_busy;
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg <= 1'b0;
        end else if (take) begin
            wr_reg <= txn.write;
        end
    end
    // ----
    // link side
    // ----
    a_busy_take: assert property (
        @(posedge link_clk) disable iff (!reset_n) take |=> txn_busy)
        else $error("busy not raised after take");
    a_answer_bound: assert property (
        @(posedge link_clk) disable iff (!reset_n) take |-> ##[3:20] rsp_valid)
        else $error("no answer in time");
    a_rsp_single: assert property (
        @(posedge link_clk) disable iff (!reset_n) rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    a_busy_drop: assert property (
        @(posedge link_clk) disable iff (!reset_n)
        rsp_valid |-> !txn_busy && $past(txn_busy))
        else $error("busy wrong around answer");
    a_data_hold: assert property (
        @(posedge link_clk) disable iff (!reset_n)
        !rsp_valid |-> $stable(rsp_data))
        else $error("answer data moved between answers");
    a_write_zero: assert property (
        @(posedge link_clk) disable iff (!reset_n)
        rsp_valid && wr_reg |-> rsp_data == 8'h00)
        else $error("write answer not zero");
    // ----
    // phase count
    // ----
    a_clamp_a: assert property (
        @(posedge clk) disable iff (!reset_n) phase_count_load[0] |=>
        operating_phase_count[0] == (($past(phase_count_select[0]) >
        PHASE_MAX[0]) ? PHASE_MAX[0] : $past(phase_count_select[0])))
        else $error("phase count a not clamped");
    a_clamp_b: assert property (
        @(posedge clk) disable iff (!reset_n) phase_count_load[1] |=>
        operating_phase_count[1] == (($past(phase_count_select[1]) >
        PHASE_MAX[1]) ? PHASE_MAX[1] : $past(phase_count_select[1])))
        else $error("phase count b not clamped");
    a_count_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        phase_count_load == 2'h0 |=> $stable(operating_phase_count))
        else $error("phase count moved without load");
    c_take: cover property (@(posedge link_clk) take);
    c_write: cover property (@(posedge link_clk) rsp_valid && wr_reg);
    c_load: cover property (@(posedge clk) phase_count_load == 2'h3);
endmodule
`default_nettype wire

// *** verif/pfs_host.sv ***
// host model issuing read byte and write byte requests on the link
// assumes link_clk comes from the bench; requests start after reset
`timescale 1ns/10ps
`default_nettype none
module pfs_host (
    input wire logic link_clk,
    output var logic txn_valid,
    output var pfs_pkg::pfs_txn_t txn,
    input wire logic txn_busy,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data
);
    import pfs_pkg::*;
    initial begin
        txn_valid = 1'b0;
        txn = '0;
    end
    // one transfer; held until the falling edge after the take edge, then scrambled so a
    // late sample of a released request never looks valid
    task automatic access(input logic wr, input logic [7:0] cmd,
            input logic [7:0] page, input logic [7:0] wdata,
            output logic [7:0] rd);
        int n;
        @(negedge link_clk);
        txn_valid = 1'b1;
        txn = '{write: wr, cmd: cmd, page: page, wdata: wdata};
        n = 0;
        while (txn_busy !== 1'b0 && n < 40) begin
            @(negedge link_clk);
            n++;
        end
        @(negedge link_clk);
        txn_valid = 1'b0;
        txn = pfs_txn_t'(~txn);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge link_clk);
            n++;
        end
        rd = (n < 40) ? rsp_data : 8'hxx; // a hang shows as unknown
    endtask
endmodule
`default_nettype wire

// *** verif/pfs_status_bank_tb_top.sv ***
// bench for the fault status bank: host model on link, events on clk
// assumes pfs_pkg, the bank, pfs_host and pfs_chk are compiled first
`timescale 1ns/10ps
`default_nettype none
module pfs_status_bank_tb_top;
    import pfs_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic txn_valid, txn_busy, rsp_valid;
    pfs_txn_t txn;
    logic [7:0] rsp_data, rd;
    pfs_input_evt_t input_evt = '0;
    pfs_chan_evt_t [1:0] chan_evt = '0;
    pfs_comm_evt_t comm_evt = '0;
    logic detect_cycle = 1'b0;
    logic [3:0] phase_imbalance_warn = 4'h0;
    logic [1:0] temp_sense_input = 2'h0;
    logic [1:0] soft_start_begin = 2'h0;
    logic [1:0] phase_count_load = 2'h0;
    logic [1:0][2:0] phase_count_select = '0;
    logic [1:0][2:0] operating_phase_count;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    pfs_status_bank pfs_status_bank_i (.clk, .reset_n, .link_clk,
        .txn_valid, .txn, .txn_busy, .rsp_valid, .rsp_data, .input_evt,
        .chan_evt, .comm_evt, .detect_cycle, .phase_imbalance_warn,
        .temp_sense_input, .soft_start_begin, .phase_count_load,
        .phase_count_select, .operating_phase_count);
    pfs_host pfs_host_i (.link_clk, .txn_valid, .txn, .txn_busy,
        .rsp_valid, .rsp_data);
    // ----
    // clocks, watchdog, helpers
    // ----
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #3; // link phase unrelated to the core clock
        forever #6 link_clk = ~link_clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdc(input logic [7:0] cmd, input logic [7:0] page,
            input logic [7:0] exp);
        pfs_host_i.access(1'b0, cmd, page, 8'h00, rd);
        chk($sformatf("cmd %h page %h", cmd, page), exp, rd);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] page,
            input logic [7:0] d);
        pfs_host_i.access(1'b1, cmd, page, d, rd);
        chk("write answer", 8'h00, rd);
    endtask
    // one-cycle event pulses on the core clock
    task automatic pulse(input pfs_input_evt_t i, input pfs_chan_evt_t a,
            input pfs_chan_evt_t b, input pfs_comm_evt_t m);
        @(negedge clk);
        input_evt = i;
        chan_evt = {b, a};
        comm_evt = m;
        @(negedge clk);
        input_evt = '0;
        chan_evt = '0;
        comm_evt = '0;
    endtask
    task automatic detect(input logic [3:0] w, input int n);
        repeat (n) begin
            @(negedge clk);
            phase_imbalance_warn = w;
            detect_cycle = 1'b1;
            @(negedge clk);
            detect_cycle = 1'b0;
        end
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        rdc(CMD_INPUT_STATUS, PAGE_CHAN_A, 8'h00);
        rdc(CMD_TEMP_STATUS, PAGE_CHAN_B, 8'h00);
        rdc(CMD_CML_STATUS, PAGE_ALL, 8'h00);
        rdc(CMD_VENDOR_STATUS, PAGE_CHAN_B, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_input();
        int pos [6] = '{0, 1, 2, 3, 4, 7};
        logic [7:0] b;
        for (int i = 0; i < 6; i++) begin
            b = 8'h01 << pos[i];
            pulse(pfs_input_evt_t'(6'h01 << i), '0, '0, '0);
            rdc(CMD_INPUT_STATUS, PAGE_CHAN_B, b);
            wr(CMD_INPUT_STATUS, PAGE_CHAN_A, ~b);
            rdc(CMD_INPUT_STATUS, PAGE_ALL, b);
            wr(CMD_INPUT_STATUS, PAGE_CHAN_B, b);
            rdc(CMD_INPUT_STATUS, PAGE_CHAN_A, 8'h00);
        end
        $display("test input done");
    endtask
    task automatic t_temp();
        pulse('0, 5'h08, 5'h10, '0);
        rdc(CMD_TEMP_STATUS, PAGE_CHAN_A, 8'h40);
        rdc(CMD_TEMP_STATUS, PAGE_CHAN_B, 8'h80);
        rdc(CMD_TEMP_STATUS, PAGE_ALL, 8'h40);
        wr(CMD_TEMP_STATUS, PAGE_CHAN_B, 8'hff);
        rdc(CMD_TEMP_STATUS, PAGE_CHAN_B, 8'h00);
        rdc(CMD_TEMP_STATUS, PAGE_CHAN_A, 8'h40);
        wr(CMD_TEMP_STATUS, PAGE_ALL, 8'hc0);
        rdc(CMD_TEMP_STATUS, PAGE_CHAN_A, 8'h00);
        $display("test temperature done");
    endtask
    task automatic t_cml();
        pulse('0, '0, '0, 4'hf);
        rdc(CMD_CML_STATUS, PAGE_CHAN_B, 8'h6a);
        rdc(8'h55, PAGE_CHAN_A, 8'h00);
        rdc(CMD_CML_STATUS, PAGE_CHAN_A, 8'hea);
        wr(CMD_CML_STATUS, PAGE_CHAN_B, 8'hff);
        rdc(CMD_TEMP_STATUS, 8'h02, 8'h00);
        rdc(CMD_CML_STATUS, PAGE_ALL, 8'h40);
        wr(CMD_CML_STATUS, PAGE_CHAN_A, 8'h40);
        $display("test comm done");
    endtask
    task automatic t_vendor();
        pulse('0, 5'h07, 5'h07, '0);
        @(negedge clk);
        temp_sense_input = 2'h1;
        repeat (4) @(negedge clk);
        soft_start_begin = 2'h3;
        phase_count_select = {3'h1, 3'h5}; // b at its max, a above
        phase_count_load = 2'h3;
        @(negedge clk);
        soft_start_begin = 2'h0;
        phase_count_load = 2'h0;
        @(negedge clk);
        chk("count a", 8'h03, {5'h00, operating_phase_count[0]});
        chk("count b", 8'h01, {5'h00, operating_phase_count[1]});
        detect(4'h9, 6);
        rdc(CMD_VENDOR_STATUS, PAGE_CHAN_B, 8'hc0);
        detect(4'h8, 1);
        detect(4'h1, 6);
        rdc(CMD_VENDOR_STATUS, PAGE_CHAN_A, 8'hf8);
        rdc(CMD_VENDOR_STATUS, PAGE_CHAN_B, 8'hc1);
        wr(CMD_VENDOR_STATUS, PAGE_ALL, 8'hff);
        rdc(CMD_VENDOR_STATUS, PAGE_ALL, 8'h00);
        rdc(CMD_VENDOR_STATUS, PAGE_CHAN_B, 8'h00);
        $display("test vendor done");
    endtask
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_input();
        t_temp();
        t_cml();
        t_vendor();
        close_out();
    end
endmodule
bind pfs_status_bank pfs_chk pfs_chk_i (.clk, .reset_n, .link_clk,
    .txn_valid, .txn, .txn_busy, .rsp_valid, .rsp_data, .phase_count_load,
    .phase_count_select, .operating_phase_count);
`default_nettype wire
